//--- bench/bnem_bus_peer.sv
// Model of the other bus nodes that drive the shared lines
`timescale 1ns/1ps
module bnem_bus_peer (
  // Shared bus lines
  output logic [bnem_pkg::DATA_W-1:0] bus_data,
  output logic [bnem_pkg::ECC_W-1:0]  bus_ecc,
  output logic [bnem_pkg::CTRL_N-1:0] bus_ctrl,
  output logic                        bus_err
);
  import bnem_pkg::*;
  // Drive one bus cycle
  task automatic put(input logic [DATA_W-1:0] d, input logic [ECC_W-1:0] e,
                     input logic [CTRL_N-1:0] c, input logic r);
    bus_data = d;
    bus_ecc  = e;
    bus_ctrl = c;
    bus_err  = r;
  endtask : put
  // Released data floats, so it shows inverted; control idles low
  task automatic free();
    bus_data = ~bus_data;
    bus_ecc  = ~bus_ecc;
    bus_ctrl = '0;
    bus_err  = 1'b0;
  endtask : free
endmodule : bnem_bus_peer

//--- bench/bnem_monitor_tb_top.sv
// Self-checking bench for the bus node error monitor
`timescale 1ns/1ps
module bnem_monitor_tb_top;
  import bnem_pkg::*;
  // Misuse flag expected for each control line
  localparam int MF[CTRL_N] = '{F_STE, F_CONFIRM_MISUSE_FLAG, F_CAE, F_SHE, F_DIE};
  // Bench signals
  logic                  clk_sys, rst_n, bus_err, err_drive, arb_inhibit;
  logic                  cyc_mem_data, cyc_csr_data, cyc_csr_first;
  logic                  cyc_stalled, txn_end, txn_read, cnf_required;
  logic                  is_commander, mailbox_access, ecc_ce, ecc_uce;
  logic                  drv_data, cmd_cnf, cmd_shared, cmd_dirty;
  logic                  correctable_report_enable, node_is_cpu;
  logic                  node_is_mem, internal_fault, prio_reload;
  logic                  read_error, sw_attention;
  logic [1:0]            cyc_index, node_number, prio_value;
  logic [4:0]            fault_status_capture;
  logic [CTRL_N-1:0]     bus_ctrl, ctrl_allowed, drv_ctrl;
  logic [SYN_W-1:0]      ecc_syndrome, syn, s0;
  logic [ECC_W-1:0]      bus_ecc, sent_ecc;
  logic [CMD_W-1:0]      fault_command_capture;
  logic [NFLAG-1:0]      flag_clr, bus_fault_register, ef;
  logic [DATA_W-1:0]     bus_data, sent_data, cw, dv;
  logic [SYN_W*NSYN-1:0] syndrome_capture_registers;
  int                    mismatches, num_checks, ne, nr, np, ni;
  // Device under test and the other nodes on the bus
  bnem_monitor u_bnem_monitor (
    .clk_sys, .rst_n, .bus_data, .bus_ecc, .bus_ctrl, .bus_err,
    .cyc_mem_data, .cyc_csr_data, .cyc_csr_first, .cyc_stalled,
    .cyc_index, .txn_end, .txn_read, .ctrl_allowed, .cnf_required,
    .is_commander, .mailbox_access, .ecc_ce, .ecc_uce, .ecc_syndrome,
    .drv_data, .sent_data, .sent_ecc, .drv_ctrl, .cmd_cnf, .cmd_shared,
    .cmd_dirty, .correctable_report_enable, .node_is_cpu, .node_is_mem,
    .node_number, .internal_fault, .flag_clr, .err_drive,
    .bus_fault_register, .syndrome_capture_registers,
    .fault_command_capture, .fault_status_capture, .arb_inhibit,
    .prio_reload, .prio_value, .read_error, .sw_attention
  );
  bnem_bus_peer u_peer (.bus_data, .bus_ecc, .bus_ctrl, .bus_err);
  ////////////////////////////////////////
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Watchdog against a hung sequence
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
  // Command word, odd parity on the low 39 bits unless broken
  function automatic logic [DATA_W-1:0] mk_cmd(logic [DATA_W-1:0] d,
                                               logic bad);
    mk_cmd = d;
    mk_cmd[38] = (^d[37:0]) ^ ~bad;
  endfunction : mk_cmd
  // One-hot flag mask
  function automatic logic [NFLAG-1:0] fb(int i);
    fb = '0;
    fb[i] = 1'b1;
  endfunction : fb
  // Syndrome slot contents
  function automatic logic [SYN_W-1:0] slot(int i);
    slot = syndrome_capture_registers[i*SYN_W +: SYN_W];
  endfunction : slot
  // Value comparison
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Quiet cycle inputs
  task automatic idle();
    {cyc_mem_data, cyc_csr_data, cyc_csr_first, cyc_stalled} = 4'h0;
    {txn_end, cnf_required, is_commander, mailbox_access} = 4'h0;
    {ecc_ce, ecc_uce, drv_data, internal_fault} = 4'h0;
    {ctrl_allowed, drv_ctrl, flag_clr} = '0;
    u_peer.free();
  endtask : idle
  // Count output pulses over n cycles, inputs quiet after the first
  task automatic watch(int n);
    {ne, nr, np, ni} = '0;
    repeat (n) begin
      @(negedge clk_sys);
      ne += int'(err_drive === 1'b1);
      nr += int'(read_error === 1'b1);
      np += int'(prio_reload === 1'b1);
      ni += int'(arb_inhibit === 1'b1);
      idle();
    end
  endtask : watch
  // Let the staged event happen, then check pulse count and flags
  task automatic fire(logic [NFLAG-1:0] add, int xe);
    ef = ef | add;
    watch(7);
    if (xe >= 0) begin
      chk("err_pulses", 64'(xe), 64'(ne));
    end
    chk("flags", 64'(ef), 64'(bus_fault_register));
  endtask : fire
  // Write-one-to-clear
  task automatic clr(logic [NFLAG-1:0] m);
    flag_clr = m;
    ef = ef & ~m;
    watch(2);
    chk("cleared", 64'(ef), 64'(bus_fault_register));
  endtask : clr
  // Stage a command cycle
  task automatic cmd(logic bad);
    cw = mk_cmd({$urandom, $urandom, $urandom, $urandom}, bad);
    ctrl_allowed[C_CMD] = 1'b1;
    u_peer.put(cw, ECC_W'($urandom), 5'h04, 1'b0);
  endtask : cmd
  // Stage a memory data cycle, own copy matching the bus
  task automatic mem(logic [1:0] ix, logic ce, logic ue);
    syn = SYN_W'($urandom);
    dv = {$urandom, $urandom, $urandom, $urandom};
    {cyc_mem_data, cyc_index, ecc_ce, ecc_uce} = {1'b1, ix, ce, ue};
    {ecc_syndrome, sent_data, sent_ecc} = {syn, dv, ~dv[ECC_W-1:0]};
    u_peer.put(dv, ~dv[ECC_W-1:0], '0, 1'b0);
  endtask : mem
  // Counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(64));
    rst_n = 1'b0;
    {cmd_cnf, cmd_shared, cmd_dirty, txn_read} = 4'hA;
    {correctable_report_enable, node_is_cpu, node_is_mem} = 3'h0;
    {node_number, cyc_index, ecc_syndrome, ef} = '0;
    {sent_data, sent_ecc, mismatches, num_checks} = '0;
    u_peer.put('0, '0, '0, 1'b0);
    idle();
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    watch(2);
    chk("reset_flags", 64'h0, 64'(bus_fault_register));
    repeat (20) begin
      mem(2'($urandom), 1'b0, 1'b0);
      drv_data = 1'($urandom);
      fire('0, 0);
    end
    $display("done: clean traffic");
    cmd(1'b0);
    fire('0, 0);
    txn_read = 1'b1;
    mem(2'h2, 1'b0, 1'b1);
    s0 = syn;
    fire(fb(F_UCE), 1);
    chk("read_error", 64'h1, 64'(nr));
    chk("syndrome", 64'(s0), 64'(slot(2)));
    chk("status", 64'({cmd_cnf, cmd_shared, cmd_dirty, 2'h2}),
        64'(fault_status_capture));
    chk("cmd_cap", 64'(cw[CMD_W-1:0]),
        64'(fault_command_capture));
    mem(2'h2, 1'b1, 1'b0);
    fire('0, 0);
    correctable_report_enable = 1'b1;
    mem(2'h2, 1'b1, 1'b0);
    fire(fb(F_CE), 1);
    chk("frozen", 64'(s0), 64'(slot(2)));
    mem(2'h0, 1'b0, 1'b1);
    fire(fb(F_UNCORRECTABLE_REPEAT_FLAG), 1);
    clr(fb(F_UCE) | fb(F_UNCORRECTABLE_REPEAT_FLAG));
    mem(2'h2, 1'b0, 1'b1);
    fire(fb(F_UCE), 1);
    chk("frozen_ce", 64'(s0), 64'(slot(2)));
    clr('1);
    mem(2'h1, 1'b0, 1'b1);
    drv_data = 1'b1;
    fire(fb(F_UCE) | fb(F_TDE), 1);
    chk("syndrome", 64'(syn), 64'(slot(1)));
    clr('1);
    $display("done: ecc");
    cmd(1'b1);
    fire(fb(F_CPE), 1);
    chk("cmd_cap", 64'(cw[CMD_W-1:0]),
        64'(fault_command_capture));
    mem(2'h0, 1'b0, 1'b1);
    fire('0, 0);
    txn_end = 1'b1;
    fire('0, 0);
    cmd(1'b1);
    fire(fb(F_COMMAND_PARITY_REPEAT_FLAG), 1);
    txn_end = 1'b1;
    fire('0, 0);
    clr('1);
    cmd(1'b0);
    fire('0, 0);
    {cyc_csr_data, cyc_index} = 3'h7;
    u_peer.put(mk_cmd(dv, 1'b1), '0, '0, 1'b0);
    fire(fb(F_CSR_DATA_PARITY_FLAG), 1);
    chk("csr_stat", 64'({cmd_cnf, cmd_shared, cmd_dirty, 2'h0}),
        64'(fault_status_capture));
    chk("csr_cmd", 64'(cw[CMD_W-1:0]),
        64'(fault_command_capture));
    {cyc_csr_data, internal_fault} = 2'h3;
    u_peer.put(mk_cmd(dv, 1'b1), '0, '0, 1'b0);
    fire(fb(F_CDP2) | fb(F_NODE_INTERNAL_ERROR_FLAG), 1);
    txn_end = 1'b1;
    fire('0, 0);
    clr('1);
    $display("done: command parity");
    for (int i = 0; i < CTRL_N; i++) begin
      u_peer.put(mk_cmd(dv, 1'b0), '0, 5'h01 << i, 1'b0);
      fire(fb(MF[i]), 1);
      clr('1);
    end
    for (int k = 0; k < 3; k++) begin
      {is_commander, mailbox_access} = {k != 2, k == 0};
      cnf_required = 1'b1;
      ctrl_allowed = 5'h02;
      fire(k == 1 ? fb(F_NO_RESPONDER_FLAG) : '0, int'(k == 1));
    end
    clr('1);
    $display("done: control lines");
    mem(2'h3, 1'b0, 1'b0);
    drv_data = 1'b1;
    sent_data[100] = ~sent_data[100];
    fire(fb(F_DATA_ECHO_MISMATCH_FLAG), 1);
    clr('1);
    node_is_mem = 1'b1;
    mem(2'h0, 1'b0, 1'b0);
    {cyc_mem_data, cyc_csr_data, cyc_csr_first, drv_data} = 4'h7;
    sent_data[5] = ~sent_data[5];
    fire(fb(F_DATA_ECHO_MISMATCH_FLAG), 1);
    clr('1);
    drv_ctrl = 5'h08;
    ctrl_allowed = '1;
    fire(fb(F_CONTROL_ECHO_MISMATCH_FLAG), 1);
    clr('1);
    $display("done: echo");
    {node_is_cpu, node_is_mem, node_number} = 4'hA;
    u_peer.put(dv, '0, '0, 1'b1);
    ef = fb(F_E);
    watch(24);
    chk("inhibit", 64'(INHIBIT_N), 64'(ni));
    chk("reload", 64'h1, 64'(np));
    chk("prio", 64'(node_number), 64'(prio_value));
    chk("flags", 64'(ef), 64'(bus_fault_register));
    chk("attention", 64'h1, 64'(sw_attention));
    {node_is_cpu, node_is_mem} = 2'h1;
    @(negedge clk_sys);
    chk("mem_quiet", 64'h0, 64'(sw_attention));
    internal_fault = 1'b1;
    fire(fb(F_NODE_INTERNAL_ERROR_FLAG), -1);
    $display("done: error line");
    wrap_up();
  end
endmodule : bnem_monitor_tb_top

//--- rtl/bnem_monitor.sv
// Per-node bus error monitor: checks, capture, flags and error pulse
`timescale 1ns/1ps
module bnem_monitor (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  // Observed bus lines
  input  wire logic [bnem_pkg::DATA_W-1:0]    bus_data,
  input  wire logic [bnem_pkg::ECC_W-1:0]     bus_ecc,
  input  wire logic [bnem_pkg::CTRL_N-1:0]    bus_ctrl,
  input  wire logic                           bus_err,
  // Cycle decode from protocol logic
  input  wire logic                           cyc_mem_data,
  input  wire logic                           cyc_csr_data,
  input  wire logic                           cyc_csr_first,
  input  wire logic                           cyc_stalled,
  input  wire logic [1:0]                     cyc_index,
  input  wire logic                           txn_end,
  input  wire logic                           txn_read,
  input  wire logic [bnem_pkg::CTRL_N-1:0]    ctrl_allowed,
  input  wire logic                           cnf_required,
  input  wire logic                           is_commander,
  input  wire logic                           mailbox_access,
  // ECC decode results for current data cycle
  input  wire logic                           ecc_ce,
  input  wire logic                           ecc_uce,
  input  wire logic [bnem_pkg::SYN_W-1:0]     ecc_syndrome,
  // Own drive state and sent values
  input  wire logic                           drv_data,
  input  wire logic [bnem_pkg::DATA_W-1:0]    sent_data,
  input  wire logic [bnem_pkg::ECC_W-1:0]     sent_ecc,
  input  wire logic [bnem_pkg::CTRL_N-1:0]    drv_ctrl,
  // Status latched at command
  input  wire logic                           cmd_cnf,
  input  wire logic                           cmd_shared,
  input  wire logic                           cmd_dirty,
  // Configuration
  input  wire logic                           correctable_report_enable,
  input  wire logic                           node_is_cpu,
  input  wire logic                           node_is_mem,
  input  wire logic [1:0]                     node_number,
  input  wire logic                           internal_fault,
  input  wire logic [bnem_pkg::NFLAG-1:0]     flag_clr,
  // Outputs
  output logic                                err_drive,
  output logic [bnem_pkg::NFLAG-1:0]          bus_fault_register,
  output logic [bnem_pkg::SYN_W*bnem_pkg::NSYN-1:0] syndrome_capture_registers,
  output logic [bnem_pkg::CMD_W-1:0]          fault_command_capture,
  output logic [4:0]                          fault_status_capture,
  output logic                                arb_inhibit,
  output logic                                prio_reload,
  output logic [1:0]                          prio_value,
  output logic                                read_error,
  output logic                                sw_attention
);
  import bnem_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction tracking
  bnem_state_t st_q;
  bnem_state_t st_d;
  logic [CMD_W-1:0] cmd_q;
  logic [CMD_W-1:0] cmd_d;
  logic cmd_cyc;
  logic cpe_ev;
  logic chk_ok;

  assign cmd_cyc = bus_ctrl[C_CMD] & ctrl_allowed[C_CMD];
  // Even parity over command field flags an error
  assign cpe_ev  = cmd_cyc & ~(^bus_data[CMD_W-1:0]);
  assign chk_ok  = (st_q == BNEM_ACT);

  // Next state of transaction tracker
  always_comb begin
    st_d  = st_q;
    cmd_d = cmd_q;
    case (st_q)
      BNEM_IDLE, BNEM_ACT, BNEM_SKIP: begin
        if (cmd_cyc) begin
          cmd_d = bus_data[CMD_W-1:0];
          st_d  = cpe_ev ? BNEM_SKIP : BNEM_ACT;
        end else if (txn_end) begin
          st_d = BNEM_IDLE;
        end
      end
      default: st_d = BNEM_IDLE;
    endcase
  end

  // Register tracker
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q  <= BNEM_IDLE;
      cmd_q <= '0;
    end else begin
      st_q  <= st_d;
      cmd_q <= cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error event detection
  logic ce_ev;
  logic uce_ev;
  logic csr_data_parity_flag_ev;
  logic [CTRL_N-1:0] misuse_ev;
  logic nxa_ev;
  logic dtc_ev;
  logic ctc_ev;
  logic any_ev;
  logic tde_ev;
  logic [CMD_W-1:0] echo_lo;
  logic echo_hi;

  assign uce_ev  = chk_ok & cyc_mem_data & ecc_uce;
  assign ce_ev   = chk_ok & cyc_mem_data & ecc_ce
                 & correctable_report_enable;
  // CSR parity checked only by processor and I/O nodes
  assign csr_data_parity_flag_ev = chk_ok & cyc_csr_data & ~node_is_mem
                 & ~(^bus_data[CMD_W-1:0]);
  assign misuse_ev = bus_ctrl & ~ctrl_allowed;
  assign nxa_ev  = is_commander & cnf_required & ~bus_ctrl[C_CNF]
                 & ~mailbox_access;
  assign echo_lo = bus_data[CMD_W-1:0] ^ sent_data[CMD_W-1:0];
  assign echo_hi = |(bus_data[DATA_W-1:CMD_W] ^ sent_data[DATA_W-1:CMD_W])
                 | |(bus_ecc ^ sent_ecc);
  // Full echo on memory data; low field on command, first CSR, stalled
  assign dtc_ev  = drv_data & ((cyc_mem_data & ~cyc_stalled
                   & ((|echo_lo) | echo_hi))
                 | ((cmd_cyc | cyc_csr_first | cyc_stalled)
                   & (|echo_lo)));
  assign ctc_ev  = |(drv_ctrl & ~bus_ctrl);
  assign tde_ev  = drv_data & (ce_ev | uce_ev | cpe_ev | csr_data_parity_flag_ev);
  // Merged single pulse source
  assign any_ev  = ce_ev | uce_ev | cpe_ev | csr_data_parity_flag_ev | (|misuse_ev)
                 | nxa_ev | dtc_ev | ctc_ev | internal_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags
  logic [NFLAG-1:0] set_vec;
  logic [NFLAG-1:0] flag_w;
  logic [3:0]       rep_w;

  always_comb begin
    set_vec          = FLAGS_RST;
    set_vec[F_CE]    = ce_ev;
    set_vec[F_UCE]   = uce_ev;
    set_vec[F_CPE]   = cpe_ev;
    set_vec[F_CSR_DATA_PARITY_FLAG]  = csr_data_parity_flag_ev;
    set_vec[F_TDE]   = tde_ev;
    set_vec[F_STE]   = misuse_ev[C_STALL];
    set_vec[F_CONFIRM_MISUSE_FLAG]  = misuse_ev[C_CNF];
    set_vec[F_CAE]   = misuse_ev[C_CMD];
    set_vec[F_SHE]   = misuse_ev[C_SHR];
    set_vec[F_DIE]   = misuse_ev[C_DRT];
    set_vec[F_NO_RESPONDER_FLAG]  = nxa_ev;
    set_vec[F_DATA_ECHO_MISMATCH_FLAG]  = dtc_ev;
    set_vec[F_CONTROL_ECHO_MISMATCH_FLAG]  = ctc_ev;
    set_vec[F_NODE_INTERNAL_ERROR_FLAG]  = internal_fault;
    set_vec[F_E]     = bus_err;
  end

  // One sticky cell per flag except the four repeat flags; first four carry repeat companions
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      if (gi >= F_CE2 && gi <= F_CDP2) begin : g_rep
        assign flag_w[gi] = rep_w[gi-F_CE2];
      end else begin : g_cell
        logic rep_o_w;
        bnem_sticky u_cell (
          .clk_sys (clk_sys),
          .rst_n   (rst_n),
          .set_in  (set_vec[gi]),
          .clr_in  (flag_clr[gi]
                    | flag_clr[(gi < F_CE2) ? gi + F_CE2 : gi]),
          .flag_o  (flag_w[gi]),
          .rep_o   (rep_o_w)
        );
        if (gi < F_CE2) begin : g_r
          assign rep_w[gi] = rep_o_w;
        end
      end
    end
  endgenerate
  assign bus_fault_register = flag_w;

  ////////////////////////////////////////////////////////////////////////////
  // Capture registers
  logic frozen;
  logic cap_ecc;
  logic cap_cmd;
  logic [SYN_W*NSYN-1:0] syn_q;
  logic [SYN_W*NSYN-1:0] syn_d;
  logic [CMD_W-1:0]      ccap_q;
  logic [CMD_W-1:0]      ccap_d;
  logic [4:0]            stat_q;
  logic [4:0]            stat_d;

  assign frozen  = flag_w[F_CE] | flag_w[F_UCE];
  assign cap_ecc = ~frozen & (ce_ev | uce_ev);
  assign cap_cmd = ~frozen & ~cap_ecc & (cpe_ev | csr_data_parity_flag_ev);

  // Capture next values
  always_comb begin
    syn_d  = syn_q;
    ccap_d = ccap_q;
    stat_d = stat_q;
    if (cap_ecc) begin
      syn_d[cyc_index*SYN_W +: SYN_W] = ecc_syndrome;
      ccap_d = cmd_q;
      stat_d = {cmd_cnf, cmd_shared, cmd_dirty, cyc_index};
    end else if (cap_cmd) begin
      ccap_d = cpe_ev ? bus_data[CMD_W-1:0] : cmd_q;
      stat_d = {cmd_cnf, cmd_shared, cmd_dirty, DCYC_ZERO};
    end
  end

  // Register captures
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syn_q  <= '0;
      ccap_q <= '0;
      stat_q <= 5'h00;
    end else begin
      syn_q  <= syn_d;
      ccap_q <= ccap_d;
      stat_q <= stat_d;
    end
  end
  assign syndrome_capture_registers = syn_q;
  assign fault_command_capture      = ccap_q;
  assign fault_status_capture       = stat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Error pulse, inhibit counter, priority and read error
  logic [PULSE_DLY-1:0] pp_q;
  logic [PULSE_DLY-1:0] pp_d;
  logic                 err_q;
  logic                 err_d;
  logic [4:0]           inh_q;
  logic [4:0]           inh_d;
  logic                 rd_q;
  logic                 rd_d;
  logic                 pr_q;
  logic                 pr_d;

  // Pipeline the merged event; output pulse is one cycle wide
  always_comb begin
    pp_d  = {pp_q[PULSE_DLY-2:0], any_ev};
    err_d = pp_q[PULSE_DLY-1] & ~err_q;
    inh_d = bus_err ? 5'(INHIBIT_N)
          : (inh_q != CNT_ZERO) ? inh_q - 5'h01 : inh_q;
    rd_d  = uce_ev & txn_read;
    pr_d  = bus_err & node_is_cpu;
  end

  // Register pulse state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pp_q  <= '0;
      err_q <= 1'b0;
      inh_q <= CNT_ZERO;
      rd_q  <= 1'b0;
      pr_q  <= 1'b0;
    end else begin
      pp_q  <= pp_d;
      err_q <= err_d;
      inh_q <= inh_d;
      rd_q  <= rd_d;
      pr_q  <= pr_d;
    end
  end

  assign err_drive    = err_q;
  assign arb_inhibit  = (inh_q != CNT_ZERO);
  assign prio_reload  = pr_q;
  assign prio_value   = node_number;
  assign read_error   = rd_q;
  // Memory nodes never request software attention
  assign sw_attention = ~node_is_mem & (|flag_w);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_uce_sets;
    @(posedge clk_sys) disable iff (!rst_n)
      uce_ev |=> bus_fault_register[F_UCE];
  endproperty
  a_uce_sets: assert property (p_uce_sets) else $error("uce not set");

  property p_err_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      any_ev |-> ##[1:4] err_drive;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("no err pulse");

  property p_err_one;
    @(posedge clk_sys) disable iff (!rst_n)
      err_drive |=> !err_drive;
  endproperty
  a_err_one: assert property (p_err_one) else $error("err too long");

  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
      frozen |=> $stable(syndrome_capture_registers);
  endproperty
  a_freeze: assert property (p_freeze) else $error("capture changed");

  property p_cpe_skip;
    @(posedge clk_sys) disable iff (!rst_n)
      (cpe_ev && !txn_end) |=> !uce_ev && !csr_data_parity_flag_ev;
  endproperty
  a_cpe_skip: assert property (p_cpe_skip) else $error("checked skipped");

  property p_repeat;
    @(posedge clk_sys) disable iff (!rst_n)
      (cpe_ev && bus_fault_register[F_CPE]) |=> bus_fault_register[F_COMMAND_PARITY_REPEAT_FLAG];
  endproperty
  a_repeat: assert property (p_repeat) else $error("no repeat flag");

  property p_inhibit;
    @(posedge clk_sys) disable iff (!rst_n)
      bus_err |=> arb_inhibit [*8];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("no inhibit");

  property p_nxa_mbox;
    @(posedge clk_sys) disable iff (!rst_n)
      (mailbox_access && !bus_fault_register[F_NO_RESPONDER_FLAG] && !flag_clr[F_NO_RESPONDER_FLAG])
      |=> !($rose(bus_fault_register[F_NO_RESPONDER_FLAG]) && $past(mailbox_access));
  endproperty
  a_nxa_mbox: assert property (p_nxa_mbox) else $error("no_responder_flag on mailbox");
endmodule : bnem_monitor

//--- rtl/bnem_pkg.sv
// Package of constants for the bus node error monitor
// Functional notes
// - Command parity error drops the transaction; other errors keep processing it.
// - Uncorrectable memory ECC error pulses error line once within four cycles.
// - ECC error captures syndromes, command, status and data cycle index.
// - Correctable ECC error reports only when enabled, setting correctable flag.
// - Capture registers freeze until both ECC flags are cleared by writing one.
// - Frozen capture still lets new errors set their flags.
// - Command cycle checked for odd parity over 39 bits; capture and flag.
// - After command parity error, skip ECC and CSR data parity checks for that transaction.
// - CSR data parity error pulses, captures command, zero cycle, sets flag.
// - Repeat flag set when same error type recurs while flag is set.
// - Transmitter flag set with ECC or parity flag when node drove data.
// - Control line asserted when not permitted pulses error and sets misuse flag.
// - Commander flags no-responder when confirm is missing where required.
// - No no-responder flag for CSR accesses to mailbox pointer register.
// - Driven memory data cycle echo mismatch pulses and sets data echo flag.
// - Command, first CSR and stalled cycles echo-check low 39 bits only.
// - Driven control line not seen asserted sets control echo flag.
// - Internal fault sets node internal error flag; pulse optional.
// - Seen error line sets general flag and blocks arbitration 16 cycles.
// - Processor node reloads arbitration priority from node number on error.
// - Uncorrectable error on a read returns read error instead of data.
// - Memory nodes take no recovery action on logged errors.
package bnem_pkg;
  localparam int DATA_W    = 128;
  localparam int ECC_W     = 28;
  localparam int CMD_W     = 39;
  localparam int SYN_W     = 7;
  localparam int NSYN      = 4;
  localparam int INHIBIT_N = 16;
  localparam int CTRL_N    = 5;
  // Flag vector positions
  localparam int F_CE   = 0;
  localparam int F_UCE  = 1;
  localparam int F_CPE  = 2;
  localparam int F_CSR_DATA_PARITY_FLAG = 3;
  localparam int F_CE2  = 4;
  localparam int F_UNCORRECTABLE_REPEAT_FLAG = 5;
  localparam int F_COMMAND_PARITY_REPEAT_FLAG = 6;
  localparam int F_CDP2 = 7;
  localparam int F_TDE  = 8;
  localparam int F_STE  = 9;
  localparam int F_CONFIRM_MISUSE_FLAG = 10;
  localparam int F_NO_RESPONDER_FLAG = 11;
  localparam int F_CAE  = 12;
  localparam int F_SHE  = 13;
  localparam int F_DIE  = 14;
  localparam int F_DATA_ECHO_MISMATCH_FLAG = 15;
  localparam int F_CONTROL_ECHO_MISMATCH_FLAG = 16;
  localparam int F_NODE_INTERNAL_ERROR_FLAG = 17;
  localparam int F_E    = 18;
  localparam int NFLAG  = 19;
  // Control line positions
  localparam int C_STALL = 0;
  localparam int C_CNF   = 1;
  localparam int C_CMD   = 2;
  localparam int C_SHR   = 3;
  localparam int C_DRT   = 4;
  localparam logic [NFLAG-1:0] FLAGS_RST = 19'h00000;
  localparam logic [4:0]       CNT_ZERO  = 5'h00;
  localparam logic [1:0]       DCYC_ZERO = 2'h0;
  // Error pulse pipeline stages before the line (within four cycles)
  localparam int PULSE_DLY = 2;
  typedef enum logic [2:0] {
    BNEM_IDLE  = 3'b001,
    BNEM_ACT   = 3'b010,
    BNEM_SKIP  = 3'b100
  } bnem_state_t;
endpackage : bnem_pkg

//--- rtl/bnem_sticky.sv
// Sticky flag with write-one-to-clear and repeat companion
`timescale 1ns/1ps
module bnem_sticky (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Event and clear
  input  wire logic set_in,
  input  wire logic clr_in,
  // Flag outputs
  output logic      flag_o,
  output logic      rep_o
);
  logic flag_q;
  logic flag_d;
  logic rep_q;
  logic rep_d;

  // Set wins over clear; repeat on set while already set
  always_comb begin
    flag_d = set_in | (flag_q & ~clr_in);
    rep_d  = (set_in & flag_q) | (rep_q & ~clr_in);
  end

  // Register flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      rep_q  <= 1'b0;
    end else begin
      flag_q <= flag_d;
      rep_q  <= rep_d;
    end
  end

  assign flag_o = flag_q;
  assign rep_o  = rep_q;
endmodule : bnem_sticky
